/* src/adc_ctrl_consts.vh */
// Purpose: constants for the converter serial front-end control
// Assumes: 40 MHz system clock, times in nanoseconds
// Notes: definitions only
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH
`define CLK_PERIOD_NS 25
`define TRACK_RISE_EDGE 5'd13
`define NORMAL_FALL_EDGE 5'd10
`define PD_MIN_FALL_EDGE 5'd2
`define PARTIAL_WAKE_NS 1000
`define PARTIAL_WAKE_CYC ((`PARTIAL_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FULL_WAKE_NS 1500000
`define FULL_WAKE_CYC (`FULL_WAKE_NS / `CLK_PERIOD_NS)
`define MODE_NORMAL 2'd0
`define MODE_PARTIAL 2'd1
`define MODE_FULL 2'd2
`define MODE_UNKNOWN 2'd3
`endif

/* src/adc_input_select_power_sequencing.v */
// Purpose: track/hold, input configuration and power-mode sequencing of the converter front end
// Assumes: chip select and serial clock come from the host, sampled on clk
// Notes: serial clock edges counted per frame from chip select falling edge
`timescale 1ns/10ps
`include "adc_ctrl_consts.vh"

// Notes on behaviour
// R1: config pin low gives three differential pairs; high gives six single-ended inputs.
// R2: single-ended mode ties the selected channel negative input to analog ground.
// R3: host keeps config pin stable from acquisition until track resumes.
// R4: any config pin change is seen at once; mid-conversion change corrupts it. The code sees it only after the two-flop synchroniser.
// R5: track resumes on 13th rising serial clock edge after chip select falls.
// R6: host waits about 1.5 ms after chip select falls when leaving full power-down.
// R7: wake from partial power-down takes about 1 us.
// R8: with internal reference, partial power-down lasts at least 67 us.
// R9: after supplies come up the power mode is unknown.
// R10: host runs one dummy cycle before the first valid conversion.
// R11: two dummy cycles leave the converter in partial power-down.
// R12: first dummy cycle holds chip select low past the 10th falling edge.
// R13: second dummy cycle ends after 2nd and before 10th falling edge.
// R14: three dummy cycles give full power-down: normal, then two entry cycles.
// R15: each cycle starts at chip select fall; serial clock edges counted from there.
module adc_input_select_power_sequencing #(
  parameter integer FULL_WAKE_CYCLES = `FULL_WAKE_CYC,
  parameter integer PARTIAL_WAKE_CYCLES = `PARTIAL_WAKE_CYC
) (
  input wire clk,
  input wire rstn,
  input wire cs_n,
  input wire converter_serial_clock,
  input wire input_config_select,
  input wire [2:0] channel_sel,
  output reg track_mode,
  output reg single_ended,
  output reg [3:0] pos_input,
  output reg [3:0] neg_input,
  output reg neg_to_analog_ground,
  output reg conversion_corrupt,
  output reg [1:0] power_mode,
  output reg powered_up
);

  // reset asserts at once, releases after two clk edges
  reg [1:0] rst_sync_reg;
  wire rst_n_int = rst_sync_reg[1];
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // two-flop synchronisers, then one more stage for edge detect
  reg [1:0] cs_sync_reg, sck_sync_reg, cfg_sync_reg;
  reg cs_d_reg, sck_d_reg, cfg_d_reg;
  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      cs_sync_reg <= 2'b11;
      sck_sync_reg <= 2'b11;
      cfg_sync_reg <= 2'b00;
      cs_d_reg <= 1'b1;
      sck_d_reg <= 1'b1;
      cfg_d_reg <= 1'b0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      sck_sync_reg <= {sck_sync_reg[0], converter_serial_clock};
      cfg_sync_reg <= {cfg_sync_reg[0], input_config_select};
      cs_d_reg <= cs_sync_reg[1];
      sck_d_reg <= sck_sync_reg[1];
      cfg_d_reg <= cfg_sync_reg[1];
    end
  end
  wire cs_s = cs_sync_reg[1];
  wire cfg_s = cfg_sync_reg[1];
  wire cs_fall = cs_d_reg & ~cs_s; // R15
  wire cs_rise = ~cs_d_reg & cs_s;
  wire sck_rise = ~sck_d_reg & sck_sync_reg[1] & ~cs_s;
  wire sck_fall = sck_d_reg & ~sck_sync_reg[1] & ~cs_s;
  wire cfg_change = cfg_d_reg ^ cfg_s;

  // per-frame edge counters, saturating
  reg [4:0] rise_cnt_reg, fall_cnt_reg;
  reg [4:0] rise_cnt_next, fall_cnt_next;
  always @* begin
    rise_cnt_next = rise_cnt_reg;
    fall_cnt_next = fall_cnt_reg;
    if (cs_fall) begin // R15
      rise_cnt_next = 5'h00;
      fall_cnt_next = 5'h00;
    end else begin
      if (sck_rise && rise_cnt_reg != 5'h1f)
        rise_cnt_next = rise_cnt_reg + 5'h01;
      if (sck_fall && fall_cnt_reg != 5'h1f)
        fall_cnt_next = fall_cnt_reg + 5'h01;
    end
  end

  // in-frame flag: frame active from chip select fall until track resumes
  reg in_conv_reg;
  reg track_next, in_conv_next, corrupt_next;
  always @* begin
    track_next = track_mode;
    in_conv_next = in_conv_reg;
    corrupt_next = conversion_corrupt;
    if (cs_fall) begin
      track_next = 1'b0;
      in_conv_next = 1'b1;
      corrupt_next = 1'b0;
    end else if (in_conv_reg && sck_rise && rise_cnt_next == `TRACK_RISE_EDGE) begin
      track_next = 1'b1; // R5
      in_conv_next = 1'b0;
    end else if (cs_rise) begin
      track_next = 1'b1;
      in_conv_next = 1'b0;
    end
    // set wins over the clear at chip select fall
    if ((in_conv_reg || cs_fall) && cfg_change)
      corrupt_next = 1'b1; // R4
  end

  // power mode sequencing: frame end decides what follows
  reg [1:0] mode_next;
  reg [1:0] pd_seen_reg, pd_seen_next;
  reg [31:0] wake_cnt_reg, wake_cnt_next;
  reg powered_next;
  always @* begin
    mode_next = power_mode;
    pd_seen_next = pd_seen_reg;
    wake_cnt_next = wake_cnt_reg;
    powered_next = powered_up;
    // wake countdown runs through frame edges; later branches override it
    if (wake_cnt_reg != 32'h0) begin
      wake_cnt_next = wake_cnt_reg - 32'h1;
      if (wake_cnt_reg == 32'h1)
        powered_next = 1'b1;
    end
    if (cs_fall) begin
      if (power_mode == `MODE_FULL)
        wake_cnt_next = FULL_WAKE_CYCLES; // R6
      else if (power_mode == `MODE_PARTIAL)
        wake_cnt_next = PARTIAL_WAKE_CYCLES; // R7
      else if (power_mode == `MODE_UNKNOWN)
        wake_cnt_next = FULL_WAKE_CYCLES;
      if (power_mode != `MODE_NORMAL) begin
        mode_next = `MODE_NORMAL;
        powered_next = 1'b0;
      end
    end else if (cs_rise) begin
      if (fall_cnt_reg >= `NORMAL_FALL_EDGE) begin
        pd_seen_next = 2'd0; // R12
      end else if (fall_cnt_reg >= `PD_MIN_FALL_EDGE) begin
        // R13 R14
        if (pd_seen_reg == 2'd0) begin
          mode_next = `MODE_PARTIAL;
          pd_seen_next = 2'd1;
        end else begin
          mode_next = `MODE_FULL;
          pd_seen_next = 2'd0;
        end
        // stale wake count must not raise powered_up while powered down
        wake_cnt_next = 32'h0;
        powered_next = 1'b0;
      end
    end
  end

  // pair p occupies inputs 2p and 2p+1
  function [3:0] pair_input;
    input [1:0] pair;
    input odd;
    begin
      pair_input = {1'b0, pair, odd};
    end
  endfunction

  integer i;
  reg [3:0] pos_next, neg_next;
  always @* begin
    pos_next = 4'h0;
    neg_next = 4'h0;
    for (i = 0; i < 1; i = i + 1) begin
      if (cfg_s) begin
        pos_next = {1'b0, channel_sel}; // R1
        neg_next = 4'hf; // R2
      end else begin
        pos_next = pair_input(channel_sel[1:0], 1'b0); // R1
        neg_next = pair_input(channel_sel[1:0], 1'b1);
      end
    end
  end

  always @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rise_cnt_reg <= 5'h00;
      fall_cnt_reg <= 5'h00;
      track_mode <= 1'b1;
      in_conv_reg <= 1'b0;
      conversion_corrupt <= 1'b0;
      power_mode <= `MODE_UNKNOWN; // R9
      pd_seen_reg <= 2'd0;
      wake_cnt_reg <= 32'h0;
      powered_up <= 1'b0;
      single_ended <= 1'b0;
      pos_input <= 4'h0;
      neg_input <= 4'h0;
      neg_to_analog_ground <= 1'b0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      fall_cnt_reg <= fall_cnt_next;
      track_mode <= track_next;
      in_conv_reg <= in_conv_next;
      conversion_corrupt <= corrupt_next;
      power_mode <= mode_next;
      pd_seen_reg <= pd_seen_next;
      wake_cnt_reg <= wake_cnt_next;
      powered_up <= powered_next;
      single_ended <= cfg_s; // R4
      pos_input <= pos_next;
      neg_input <= neg_next;
      neg_to_analog_ground <= cfg_s; // R2
    end
  end

endmodule // adc_input_select_power_sequencing

/* tb/adc_input_select_power_sequencing_monitor.sv */
// Purpose: port checker. Assumes: bound into the top. Notes: pin-level edge counts
`timescale 1ns/10ps
module adc_input_select_power_sequencing_monitor #(
  parameter integer FULL_WAKE_CYCLES = 50,
  parameter integer PARTIAL_WAKE_CYCLES = 40
) (
  input wire clk,
  input wire rstn,
  input wire cs_n,
  input wire converter_serial_clock,
  input wire input_config_select,
  input wire track_mode,
  input wire single_ended,
  input wire [3:0] pos_input,
  input wire [3:0] neg_input,
  input wire neg_to_analog_ground,
  input wire conversion_corrupt,
  input wire [1:0] power_mode,
  input wire powered_up
);
  localparam integer P = PARTIAL_WAKE_CYCLES;
  localparam integer F = FULL_WAKE_CYCLES;
  reg [4:0] rise_cnt;
  reg [7:0] wake_cnt;
  always @(posedge clk) begin
    rise_cnt <= cs_n ? 5'h00 : rise_cnt + {4'h0, $rose(converter_serial_clock)};
    wake_cnt <= $fell(cs_n) ? 8'h00 : wake_cnt + {7'h00, ~&wake_cnt};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  diff_pair_a: assert property (
    !track_mode && !single_ended |-> neg_input == pos_input + 4'h1 && !pos_input[0])
    else $error("diff pair");
  gnd_tie_a: assert property (
    !track_mode && single_ended |-> neg_to_analog_ground && neg_input == 4'hf) else $error("gnd");
  corrupt_set_a: assert property (
    $changed(input_config_select) && !track_mode ##1 !track_mode [*6] |-> conversion_corrupt)
    else $error("corrupt");
  track_ret_a: assert property ($rose(track_mode) |-> rise_cnt == 5'd13 || cs_n)
    else $error("track");
  hold_start_a: assert property ($fell(cs_n) |-> ##[3:5] !track_mode) else $error("hold");
  wake_time_a: assert property (
    $rose(powered_up) |-> wake_cnt inside {[P+1:P+6], [F+1:F+6]}) else $error("wake");
  mode_unknown_a: assert property ($rose(rstn) |-> power_mode == 2'd3) else $error("mode");
  asleep_low_a: assert property (power_mode != 2'd0 |-> !powered_up) else $error("asleep");
  cover property ($rose(conversion_corrupt));
  cover property (power_mode == 2'd2);
  cover property ($rose(powered_up));
endmodule // adc_input_select_power_sequencing_monitor

/* tb/host_model.sv */
// Purpose: host model. Assumes: serial clock idles high. Notes: 4 clk per phase
`timescale 1ns/10ps
module host_model (
  input wire clk,
  input wire go,
  input wire [4:0] n_clk,
  output reg cs_n = 1'b1,
  output reg converter_serial_clock = 1'b1,
  output reg busy = 1'b0
);
  initial forever begin
    @(posedge clk);
    if (go) begin
      busy <= 1'b1;
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      repeat (n_clk) begin
        converter_serial_clock <= 1'b0;
        repeat (4) @(posedge clk);
        converter_serial_clock <= 1'b1;
        repeat (4) @(posedge clk);
      end
      cs_n <= 1'b1;
      repeat (16) @(posedge clk);
      busy <= 1'b0;
    end
  end
endmodule // host_model

/* tb/tb_adc_input_select_power_sequencing.sv */
// Purpose: front-end bench. Assumes: 40 MHz clk. Notes: checked at track return
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_adc_input_select_power_sequencing;
  reg clk = 1'b0, rstn = 1'b0, input_config_select = 1'b1, go = 1'b0, s;
  reg [2:0] channel_sel = 3'h0, c;
  reg [4:0] n_clk = 5'h00;
  reg [1:0] m = 2'd3;
  reg [11:0] e;
  reg [11:0] q[$];
  wire cs_n, converter_serial_clock, busy, track_mode, single_ended, powered_up;
  wire neg_to_analog_ground, conversion_corrupt;
  wire [3:0] pos_input, neg_input;
  wire [1:0] power_mode;
  integer error_cnt = 0, check_count = 0;
  host_model host (.*);
  adc_input_select_power_sequencing #(.FULL_WAKE_CYCLES(50)) dut (.*);
  initial forever #12.5 clk = ~clk;
  task frame(input [4:0] k, input chg);
    begin
      s = $urandom;
      c = (s && !chg) ? $urandom % 6 : $urandom % 3;
      input_config_select <= s;
      channel_sel <= c;
      n_clk <= k;
      repeat (4) @(posedge clk);
      go <= 1'b1;
      m = (k > 5'd9) ? 2'd0 : (m == 2'd1) ? 2'd2 : 2'd1;
      q.push_back({m, chg, s ^ chg,
        (s ^ chg) ? {1'b0, c, 4'hf} : {1'b0, c[1:0], 2'b00, c[1:0], 1'b1}});
      @(posedge clk iff busy);
      go <= 1'b0;
      if (chg) begin
        repeat (40) @(posedge clk);
        input_config_select <= ~s;
      end
      @(posedge clk iff !busy);
      $display("frame of %0d falls done", k);
    end
  endtask
  always @(posedge track_mode) if (rstn) begin
    repeat (8) @(posedge clk);
    e = q.pop_front();
    `CHK("mode", e[11:10], power_mode)
    `CHK("corrupt", e[9], conversion_corrupt)
    `CHK("mux", {e[8], e[8:0]}, {single_ended, neg_to_analog_ground, pos_input, neg_input})
    if (e[11:10] == 2'd0) `CHK("powered", 1'b1, powered_up)
  end
  task conclude;
    begin
      `CHK("pending", 0, q.size())
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    void'($urandom(32'h0a7abc63));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    frame(5'd16, 1'b0);
    frame(5'd4, 1'b0);
    repeat (2680) @(posedge clk);
    frame(5'd16, 1'b0);
    frame(5'd3, 1'b0);
    frame(5'd9, 1'b0);
    frame(5'd16, 1'b1);
    repeat (6) frame(5'd14 + $urandom % 3, 1'b0);
    repeat (20) @(posedge clk);
    conclude;
  end
  initial begin
    #500000;
    error_cnt++;
    conclude;
  end
endmodule // tb_adc_input_select_power_sequencing
bind adc_input_select_power_sequencing adc_input_select_power_sequencing_monitor #(
  .FULL_WAKE_CYCLES(FULL_WAKE_CYCLES), .PARTIAL_WAKE_CYCLES(PARTIAL_WAKE_CYCLES)) mon (.*);
